// ### core/alsp_lane_packer.sv
// Purpose: map channel samples A..D onto serial lane octets per frame
//          for link format modes 2 to 10.
// Assumes: sample inputs synchronous to clk, 12 bits left-justified.
// Notes:   lane n sits at frameData[n*40 +: 40], octet 0 in bits 39:32.
`timescale 1ns/1ps

// Summary of operation
// - Mode 2 puts one 8-bit sample of channel c in one octet on lane c.
// - Mode 3 puts four 10-bit samples of channel c in five octets on lane c.
// - Mode 4 streams A,B,C,D 12-bit samples over 16-bit lanes, 64b66b.
// - Mode 5 streams 8-bit A,B on lane 0 and C,D on lane 1, 64b66b.
// - Mode 6 streams A0,A1,B0,B1,C0,C1,D0,D1 over 16-bit lanes, 64b66b.
// - Mode 7 puts one 8-bit sample of channel c on lane c, 64b66b.
// - Mode 8 puts two 12-bit samples of channel c in three octets, 64b66b.
// - Mode 9 sends even sample on lane 2c and odd sample on lane 2c+1.
// - Mode 10 sends four even and four odd 10-bit samples on two lanes.
// - Only lanes of channels the variant has are driven; others are zero.
// - Each sample goes in most significant bit first.
// - Tail bits after the packed samples are zero.
module alsp_lane_packer
  import alsp_pkg::*;
#(
  parameter int CHANNELS = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] linkFormatMode,
  input wire logic sampleValid,
  output logic sampleReady,
  input wire logic [alsp_pkg::ALSP_SAMPLE_W-1:0] sampleA,
  input wire logic [alsp_pkg::ALSP_SAMPLE_W-1:0] sampleB,
  input wire logic [alsp_pkg::ALSP_SAMPLE_W-1:0] sampleC,
  input wire logic [alsp_pkg::ALSP_SAMPLE_W-1:0] sampleD,
  output logic frameValid,
  input wire logic frameReady,
  output logic [alsp_pkg::ALSP_FRAME_BITS-1:0] frameData,
  output logic [alsp_pkg::ALSP_LANES-1:0] frameLaneEn,
  output logic [2:0] frameOctets,
  output logic frameIs64b66b,
  output logic [3:0] frameMode,
  output logic modeError
);
  import alsp_pkg::*;

  typedef logic [ALSP_LANES-1:0][ALSP_LANE_BITS-1:0] alsp_lanes_t;
  typedef logic [ALSP_CHANS-1:0][ALSP_MAX_SPF-1:0][ALSP_SAMPLE_W-1:0]
    alsp_samples_t;

  typedef struct packed {
    alsp_state_e state;
    logic [3:0] mode;
    logic [2:0] count;
    alsp_samples_t smp;
    logic sampleReady;
    logic modeError;
  } alsp_core_s;

  alsp_core_s cur;
  alsp_core_s next_cur;
  alsp_lanes_t packedLanes;
  logic [ALSP_LANES-1:0] laneEn;
  logic bufReady;
  logic [ALSP_PAYLOAD_W-1:0] bufIn;
  logic [ALSP_PAYLOAD_W-1:0] bufOut;

  initial begin
    if (CHANNELS != 1 && CHANNELS != 2 && CHANNELS != 4) begin
      $error("alsp_lane_packer: CHANNELS must be 1, 2 or 4");
    end
  end

  // ==========================================================
  // lane mapping
  function automatic alsp_lanes_t pack_frame(input logic [3:0] m,
                                             input alsp_samples_t s);
    alsp_lanes_t l;
    int w;
    int n;
    int pos;
    l = '0;
    w = alsp_width(m);
    n = alsp_per_frame(m);
    pos = 0;
    for (int c = 0; c < ALSP_CHANS; c++) begin
      for (int k = 0; k < ALSP_MAX_SPF; k++) begin
        for (int b = 0; b < ALSP_SAMPLE_W; b++) begin
          if (k < n && b < w) begin
            unique case (m)
              ALSP_MODE_4, ALSP_MODE_5, ALSP_MODE_6: begin
                // shared lanes: one bit stream cut into 16-bit lanes
                pos = (c * n + k) * w + b;
                l[pos / ALSP_SHARED_LANE_BITS]
                  [ALSP_LANE_BITS - 1 - pos % ALSP_SHARED_LANE_BITS] =
                  s[c][k][ALSP_SAMPLE_W - 1 - b];
              end
              ALSP_MODE_9, ALSP_MODE_10: begin
                l[2 * c + k % 2][ALSP_LANE_BITS - 1 - (k / 2) * w - b] =
                  s[c][k][ALSP_SAMPLE_W - 1 - b];
              end
              default: begin
                l[c][ALSP_LANE_BITS - 1 - k * w - b] =
                  s[c][k][ALSP_SAMPLE_W - 1 - b];
              end
            endcase
          end
        end
      end
    end
    return l;
  endfunction

  // bits that must stay zero after the packed octets of each lane
  function automatic logic [ALSP_FRAME_BITS-1:0] tail_mask(
    input logic [2:0] oct);
    logic [ALSP_FRAME_BITS-1:0] msk;
    msk = '0;
    for (int ln = 0; ln < ALSP_LANES; ln++) begin
      for (int b = 0; b < ALSP_LANE_BITS; b++) begin
        if (b < ALSP_LANE_BITS - int'(oct) * ALSP_OCTET_BITS) begin
          msk[ln * ALSP_LANE_BITS + b] = 1'b1;
        end
      end
    end
    return msk;
  endfunction

  function automatic logic [ALSP_FRAME_BITS-1:0] lane_mask(
    input logic [ALSP_LANES-1:0] en);
    logic [ALSP_FRAME_BITS-1:0] msk;
    msk = '0;
    for (int ln = 0; ln < ALSP_LANES; ln++) begin
      msk[ln * ALSP_LANE_BITS +: ALSP_LANE_BITS] = {ALSP_LANE_BITS{en[ln]}};
    end
    return msk;
  endfunction

  // ==========================================================
  // framing
  always_comb begin
    alsp_lanes_t raw;
    int cnt;
    raw = '0;
    cnt = 0;
    raw = pack_frame(cur.mode, cur.smp);
    cnt = alsp_lane_count(cur.mode, CHANNELS);
    for (int ln = 0; ln < ALSP_LANES; ln++) begin
      laneEn[ln] = (ln < cnt);
      packedLanes[ln] = (ln < cnt) ? raw[ln] : '0;
    end
  end

  assign bufIn = {cur.mode, alsp_is64(cur.mode), alsp_octets(cur.mode),
                  laneEn, packedLanes};

  always_comb begin
    logic take;
    logic [ALSP_CHANS-1:0][ALSP_SAMPLE_W-1:0] in;
    take = 1'b0;
    in = '0;
    next_cur = cur;
    in = {sampleD, sampleC, sampleB, sampleA};
    take = sampleValid && cur.sampleReady;
    unique case (cur.state)
      ALSP_FILL: begin
        if (cur.count == 3'h0 && !alsp_supported(linkFormatMode)) begin
          next_cur.state = ALSP_HALT;
        end else if (take) begin
          // mode is frozen for the whole frame at its first sample
          if (cur.count == 3'h0) begin
            next_cur.mode = linkFormatMode;
          end
          for (int c = 0; c < ALSP_CHANS; c++) begin
            // absent channels carry zeros into shared lanes
            next_cur.smp[c][cur.count] = (c < CHANNELS) ? in[c] : '0;
          end
          if (int'(cur.count) ==
              alsp_per_frame((cur.count == 3'h0) ? linkFormatMode
                                                 : cur.mode) - 1) begin
            next_cur.count = 3'h0;
            next_cur.state = ALSP_SEND;
          end else begin
            next_cur.count = cur.count + 3'h1;
          end
        end
      end
      ALSP_SEND: begin
        if (bufReady) begin
          next_cur.state = ALSP_FILL;
        end
      end
      ALSP_HALT: begin
        if (alsp_supported(linkFormatMode)) begin
          next_cur.state = ALSP_FILL;
        end
      end
    endcase
    next_cur.modeError = (next_cur.state == ALSP_HALT);
    // ready is held off while a frame waits so no sample is dropped
    next_cur.sampleReady = (next_cur.state == ALSP_FILL) &&
      !(next_cur.count == 3'h0 && !alsp_supported(linkFormatMode));
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // ==========================================================
  // output buffer
  alsp_frame_buffer #(
    .WIDTH(ALSP_PAYLOAD_W),
    .DEPTH(2)
  ) u_buffer (
    .clk(clk),
    .rst_b(rst_b),
    .inValid(cur.state == ALSP_SEND),
    .inReady(bufReady),
    .inData(bufIn),
    .outValid(frameValid),
    .outReady(frameReady),
    .outData(bufOut)
  );

  assign {frameMode, frameIs64b66b, frameOctets, frameLaneEn, frameData} =
    bufOut;
  assign sampleReady = cur.sampleReady;
  assign modeError = cur.modeError;

  // ==========================================================
  // checks
  mode2_shape_a: assert property (@(posedge clk) disable iff (!rst_b)
    frameValid && frameMode == ALSP_MODE_2 |->
      frameOctets == 3'h1 && !frameIs64b66b &&
      frameLaneEn == 8'((1 << CHANNELS) - 1))
    else $error("mode 2 frame shape wrong");

  mode3_shape_a: assert property (@(posedge clk) disable iff (!rst_b)
    frameValid && frameMode == ALSP_MODE_3 |->
      frameOctets == 3'h5 && !frameIs64b66b)
    else $error("mode 3 frame shape wrong");

  mode4_lane0_a: assert property (@(posedge clk) disable iff (!rst_b)
    cur.state == ALSP_SEND && cur.mode == ALSP_MODE_4 |->
      packedLanes[0][39:28] == cur.smp[0][0] &&
      packedLanes[0][27:24] == cur.smp[1][0][11:8])
    else $error("mode 4 lane 0 layout wrong");

  mode5_lane0_a: assert property (@(posedge clk) disable iff (!rst_b)
    cur.state == ALSP_SEND && cur.mode == ALSP_MODE_5 |->
      packedLanes[0][39:24] == {cur.smp[0][0][11:4], cur.smp[1][0][11:4]})
    else $error("mode 5 lane 0 layout wrong");

  mode6_lane1_a: assert property (@(posedge clk) disable iff (!rst_b)
    cur.state == ALSP_SEND && cur.mode == ALSP_MODE_6 |->
      packedLanes[1][39:24] == {cur.smp[0][1][7:0], cur.smp[1][0][11:4]})
    else $error("mode 6 lane 1 layout wrong");

  mode7_code_a: assert property (@(posedge clk) disable iff (!rst_b)
    frameValid && frameMode == ALSP_MODE_7 |->
      frameIs64b66b && frameOctets == 3'h1)
    else $error("mode 7 frame shape wrong");

  mode8_lane0_a: assert property (@(posedge clk) disable iff (!rst_b)
    cur.state == ALSP_SEND && cur.mode == ALSP_MODE_8 |->
      packedLanes[0][39:16] == {cur.smp[0][0], cur.smp[0][1]})
    else $error("mode 8 lane 0 layout wrong");

  mode9_odd_a: assert property (@(posedge clk) disable iff (!rst_b)
    cur.state == ALSP_SEND && cur.mode == ALSP_MODE_9 |->
      packedLanes[1][39:32] == cur.smp[0][1][11:4])
    else $error("mode 9 odd sample misplaced");

  mode10_even_a: assert property (@(posedge clk) disable iff (!rst_b)
    cur.state == ALSP_SEND && cur.mode == ALSP_MODE_10 |->
      packedLanes[0][29:20] == cur.smp[0][2][11:2] &&
      packedLanes[1][39:30] == cur.smp[0][1][11:2])
    else $error("mode 10 even sample misplaced");

  idle_lanes_a: assert property (@(posedge clk) disable iff (!rst_b)
    frameValid |-> (frameData & ~lane_mask(frameLaneEn)) == '0)
    else $error("disabled lane carries data");

  tail_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
    frameValid |-> (frameData & tail_mask(frameOctets)) == '0)
    else $error("tail bits not zero");

  frame_order_a: assert property (@(posedge clk) disable iff (!rst_b)
    cur.state == ALSP_FILL && sampleValid && cur.sampleReady &&
    int'(cur.count) < alsp_per_frame(cur.mode) - 1 && cur.count != 3'h0 |=>
      cur.count == $past(cur.count) + 3'h1)
    else $error("sample index skipped");

  // a waiting frame must hold off the source, or a sample set is lost
  send_stall_a: assert property (@(posedge clk) disable iff (!rst_b)
    cur.state != ALSP_FILL |-> !sampleReady)
    else $error("samples accepted while a frame waits");

  mode3_lane1_a: assert property (@(posedge clk) disable iff (!rst_b)
    cur.state == ALSP_SEND && cur.mode == ALSP_MODE_3 |->
      packedLanes[1][29:20] == cur.smp[1][1][11:2])
    else $error("mode 3 sample misplaced");

endmodule // alsp_lane_packer

// ### core/alsp_pkg.sv
// Purpose: shared constants, states and frame-shape lookups for the
//          sample lane packer.
// Assumes: samples arrive left-justified in 12 bits.
// Notes:   frame shape is looked up per link format mode.
package alsp_pkg;

  // ==========================================================
  // widths and counts
  localparam int ALSP_SAMPLE_W = 12;
  localparam int ALSP_CHANS = 4;
  localparam int ALSP_LANES = 8;
  localparam int ALSP_MAX_SPF = 8;
  localparam int ALSP_LANE_BITS = 40;
  localparam int ALSP_SHARED_LANE_BITS = 16;
  localparam int ALSP_OCTET_BITS = 8;
  localparam int ALSP_FRAME_BITS = ALSP_LANES * ALSP_LANE_BITS;
  localparam int ALSP_PAYLOAD_W = 4 + 1 + 3 + ALSP_LANES + ALSP_FRAME_BITS;

  // ==========================================================
  // link format mode codes handled here
  localparam logic [3:0] ALSP_MODE_2 = 4'h2;
  localparam logic [3:0] ALSP_MODE_3 = 4'h3;
  localparam logic [3:0] ALSP_MODE_4 = 4'h4;
  localparam logic [3:0] ALSP_MODE_5 = 4'h5;
  localparam logic [3:0] ALSP_MODE_6 = 4'h6;
  localparam logic [3:0] ALSP_MODE_7 = 4'h7;
  localparam logic [3:0] ALSP_MODE_8 = 4'h8;
  localparam logic [3:0] ALSP_MODE_9 = 4'h9;
  localparam logic [3:0] ALSP_MODE_10 = 4'ha;

  // ==========================================================
  // packer states, gray along fill -> send -> fill
  typedef enum logic [1:0] {
    ALSP_FILL = 2'b00,
    ALSP_SEND = 2'b01,
    ALSP_HALT = 2'b11
  } alsp_state_e;

  // ==========================================================
  // frame shape lookups
  function automatic logic alsp_supported(input logic [3:0] m);
    return (m >= ALSP_MODE_2) && (m <= ALSP_MODE_10);
  endfunction

  function automatic int alsp_width(input logic [3:0] m);
    unique case (m)
      ALSP_MODE_3, ALSP_MODE_10: return 10;
      ALSP_MODE_4, ALSP_MODE_6, ALSP_MODE_8: return 12;
      default: return 8;
    endcase
  endfunction

  function automatic int alsp_per_frame(input logic [3:0] m);
    unique case (m)
      ALSP_MODE_3: return 4;
      ALSP_MODE_6, ALSP_MODE_8, ALSP_MODE_9: return 2;
      ALSP_MODE_10: return 8;
      default: return 1;
    endcase
  endfunction

  function automatic logic [2:0] alsp_octets(input logic [3:0] m);
    unique case (m)
      ALSP_MODE_3, ALSP_MODE_10: return 3'h5;
      ALSP_MODE_4, ALSP_MODE_5, ALSP_MODE_6: return 3'h2;
      ALSP_MODE_8: return 3'h3;
      default: return 3'h1;
    endcase
  endfunction

  function automatic logic alsp_is64(input logic [3:0] m);
    return (m >= ALSP_MODE_4) && (m <= ALSP_MODE_8);
  endfunction

  function automatic int alsp_lane_count(input logic [3:0] m, input int ch);
    unique case (m)
      ALSP_MODE_9, ALSP_MODE_10: return 2 * ch;
      ALSP_MODE_4: return (ch == 4) ? 3 : ch;
      ALSP_MODE_5: return (ch == 4) ? 2 : 1;
      ALSP_MODE_6: return (ch == 4) ? 6 : ((ch == 2) ? 3 : 2);
      default: return ch;
    endcase
  endfunction

endpackage

// ### core/alsp_frame_buffer.sv
// Purpose: two-entry frame buffer with valid/ready on both sides.
// Assumes: one clock, synchronous active-low reset.
// Notes:   head entry and both handshake flags come from flip-flops.
`timescale 1ns/1ps

module alsp_frame_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [$clog2(DEPTH+1)-1:0] count;
    logic full;
    logic notEmpty;
  } alsp_buf_s;

  alsp_buf_s cur;
  alsp_buf_s next_cur;

  initial begin
    if (DEPTH < 2 || WIDTH < 1) begin
      $error("alsp_frame_buffer: DEPTH must be at least 2");
    end
  end

  // ==========================================================
  // shift-down queue: head always in slot 0
  always_comb begin
    logic push;
    logic pop;
    int wr;
    push = 1'b0;
    pop = 1'b0;
    wr = 0;
    next_cur = cur;
    push = inValid && !cur.full;
    pop = cur.notEmpty && outReady;
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_cur.mem[i] = cur.mem[i+1];
      end
    end
    wr = int'(cur.count) - (pop ? 1 : 0);
    if (push) begin
      next_cur.mem[wr] = inData;
    end
    next_cur.count = $bits(cur.count)'(wr + (push ? 1 : 0));
    next_cur.full = (int'(next_cur.count) == DEPTH);
    next_cur.notEmpty = (next_cur.count != '0);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign inReady = !cur.full;
  assign outValid = cur.notEmpty;
  assign outData = cur.mem[0];

endmodule // alsp_frame_buffer

// ### tb/alsp_frame_sink.sv
// Purpose: receiver model on the frame side of the packer.
// Assumes: one frame word taken per edge with valid and ready high.
// Notes:   slow=1 takes one cycle in eight so the buffer backs up.
`timescale 1ns/1ps

module alsp_frame_sink
  import alsp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic slow,
  input wire logic frameValid,
  output logic frameReady,
  input wire logic [alsp_pkg::ALSP_FRAME_BITS-1:0] frameData,
  input wire logic [alsp_pkg::ALSP_LANES-1:0] frameLaneEn,
  input wire logic [2:0] frameOctets,
  input wire logic frameIs64b66b,
  input wire logic [3:0] frameMode
);
  logic [2:0] tick;
  logic [ALSP_PAYLOAD_W-1:0] got[$];

  // ==========================================================
  // accept frames
  always @(posedge clk) begin
    if (!rst_b) begin
      tick <= 3'h0;
      frameReady <= 1'b0;
    end else begin
      tick <= tick + 3'h1;
      frameReady <= !slow || (tick == 3'h6);
      // kept in arrival order so channel streams rebuild in time order
      if (frameValid && frameReady) begin
        got.push_back({frameMode, frameIs64b66b, frameOctets,
                       frameLaneEn, frameData});
      end
    end
  end
endmodule // alsp_frame_sink

// ### tb/adc_sample_lane_packer_tb.sv
// Purpose: self-checking bench for the sample lane packer.
// Assumes: quad and single variants in lockstep; receiver models on the
//          frame side.
// Notes:   expected frames are rebuilt bit by bit from the lane layouts.
`timescale 1ns/1ps

module adc_sample_lane_packer_tb;
  import alsp_pkg::*;
  logic clk;
  logic rst_b;
  logic [3:0] linkFormatMode;
  logic sampleValid;
  logic sampleReady;
  logic [ALSP_SAMPLE_W-1:0] sampleA, sampleB, sampleC, sampleD;
  logic frameValid;
  logic frameReady;
  logic [ALSP_FRAME_BITS-1:0] frameData;
  logic [ALSP_LANES-1:0] frameLaneEn;
  logic [2:0] frameOctets;
  logic frameIs64b66b;
  logic [3:0] frameMode;
  logic modeError;
  logic slow;
  logic oneValid;
  logic oneReady;
  logic [ALSP_FRAME_BITS-1:0] oneData;
  logic [ALSP_LANES-1:0] oneLaneEn;
  logic [2:0] oneOctets;
  logic oneIs64b66b;
  logic [3:0] oneMode;
  int nFail;
  int cmpCount;
  int nRefused;

  alsp_lane_packer #(.CHANNELS(4)) i_alsp_lane_packer (.clk(clk),
    .rst_b(rst_b), .linkFormatMode(linkFormatMode),
    .sampleValid(sampleValid), .sampleReady(sampleReady),
    .sampleA(sampleA), .sampleB(sampleB), .sampleC(sampleC),
    .sampleD(sampleD), .frameValid(frameValid), .frameReady(frameReady),
    .frameData(frameData), .frameLaneEn(frameLaneEn),
    .frameOctets(frameOctets), .frameIs64b66b(frameIs64b66b),
    .frameMode(frameMode), .modeError(modeError));

  alsp_frame_sink i_alsp_frame_sink (.clk(clk), .rst_b(rst_b),
    .slow(slow), .frameValid(frameValid), .frameReady(frameReady),
    .frameData(frameData), .frameLaneEn(frameLaneEn),
    .frameOctets(frameOctets), .frameIs64b66b(frameIs64b66b),
    .frameMode(frameMode));

  // single-channel variant shares the stimulus; its handshake timing
  // matches the quad one, so both sinks fill at the same edges
  alsp_lane_packer #(.CHANNELS(1)) i_alsp_lane_packer_1ch (.clk(clk),
    .rst_b(rst_b), .linkFormatMode(linkFormatMode),
    .sampleValid(sampleValid), .sampleReady(),
    .sampleA(sampleA), .sampleB(sampleB), .sampleC(sampleC),
    .sampleD(sampleD), .frameValid(oneValid), .frameReady(oneReady),
    .frameData(oneData), .frameLaneEn(oneLaneEn),
    .frameOctets(oneOctets), .frameIs64b66b(oneIs64b66b),
    .frameMode(oneMode), .modeError());

  alsp_frame_sink i_alsp_frame_sink_1ch (.clk(clk), .rst_b(rst_b),
    .slow(slow), .frameValid(oneValid), .frameReady(oneReady),
    .frameData(oneData), .frameLaneEn(oneLaneEn),
    .frameOctets(oneOctets), .frameIs64b66b(oneIs64b66b),
    .frameMode(oneMode));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================================
  // checking and reference
  task automatic giveVerdict();
    if (nFail == 0 && cmpCount > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chkBit(logic got, logic exp, string msg);
    cmpCount++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic chkFrame(logic [ALSP_PAYLOAD_W-1:0] got, exp, string msg);
    cmpCount++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  function automatic logic [11:0] smp(int c, int k, int base);
    return 12'(base * 12'h035 + c * 12'h4c1 + k * 12'h29f) ^ 12'ha5a;
  endfunction

  function automatic int nPer(logic [3:0] m);
    if (m == 4'h3) return 4;
    if (m == 4'ha) return 8;
    if (m inside {4'h6, 4'h8, 4'h9}) return 2;
    return 1;
  endfunction

  function automatic logic [ALSP_PAYLOAD_W-1:0] expFrame(logic [3:0] m,
                                                         int base, int ch);
    logic [ALSP_FRAME_BITS-1:0] d;
    logic [11:0] s;
    logic [2:0] oct;
    logic is64;
    logic shared;
    int w, n, lanes, g, ln, p;
    n = nPer(m);
    w = (m inside {4'h3, 4'ha}) ? 10 : (m inside {4'h4, 4'h6, 4'h8}) ? 12 : 8;
    is64 = m inside {4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
    shared = m inside {4'h4, 4'h5, 4'h6};
    oct = (m inside {4'h3, 4'ha}) ? 3'h5 : (m == 4'h8) ? 3'h3 :
          shared ? 3'h2 : 3'h1;
    // shared lanes: a partly filled last lane still counts
    if (shared) lanes = (ch * n * w + 15) / ALSP_SHARED_LANE_BITS;
    else if (m inside {4'h9, 4'ha}) lanes = 2 * ch;
    else lanes = ch;
    d = '0;
    for (int c = 0; c < ch; c++) begin
      for (int k = 0; k < n; k++) begin
        s = smp(c, k, base);
        for (int b = 0; b < w; b++) begin
          if (shared) begin
            g = (c * n + k) * w + b;
            ln = g / ALSP_SHARED_LANE_BITS;
            p = g % ALSP_SHARED_LANE_BITS;
          end else if (m inside {4'h9, 4'ha}) begin
            ln = 2 * c + k % 2;
            p = (k / 2) * w + b;
          end else begin
            ln = c;
            p = k * w + b;
          end
          // msb first, tail bits stay zero
          d[ln * ALSP_LANE_BITS + ALSP_LANE_BITS - 1 - p] = s[11 - b];
        end
      end
    end
    return {m, is64, oct, 8'((1 << lanes) - 1), d};
  endfunction

  // ==========================================================
  // drivers
  // ready is looked at on the falling edge, where the flop has settled
  task automatic sendFrame(logic [3:0] m, int base);
    int t;
    @(posedge clk);
    linkFormatMode <= m;
    for (int k = 0; k < nPer(m); k++) begin
      sampleValid <= 1'b1;
      sampleA <= smp(0, k, base);
      sampleB <= smp(1, k, base);
      sampleC <= smp(2, k, base);
      sampleD <= smp(3, k, base);
      t = 0;
      @(negedge clk);
      while (sampleReady !== 1'b1 && t < 200) begin
        nRefused++;
        t++;
        @(negedge clk);
      end
      chkBit(t < 200, 1'b1, "sample never taken");
      @(posedge clk);
    end
    sampleValid <= 1'b0;
  endtask

  task automatic checkNext(logic [3:0] m, int base);
    int t;
    t = 0;
    while ((i_alsp_frame_sink.got.size() == 0 ||
            i_alsp_frame_sink_1ch.got.size() == 0) && t < 300) begin
      @(negedge clk);
      t++;
    end
    chkBit(t < 300, 1'b1, "no frame arrived");
    if (t < 300) begin
      chkFrame(i_alsp_frame_sink.got.pop_front(), expFrame(m, base, 4),
               "frame content");
      chkFrame(i_alsp_frame_sink_1ch.got.pop_front(), expFrame(m, base, 1),
               "single-channel frame content");
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic tReset();
    @(negedge clk);
    chkBit(sampleReady, 1'b0, "ready in reset");
    chkBit(frameValid, 1'b0, "frame valid in reset");
    chkBit(modeError, 1'b0, "mode error in reset");
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(negedge clk);
    chkBit(sampleReady, 1'b1, "ready after reset");
  endtask

  task automatic tModes();
    for (int m = 2; m <= 10; m++) begin
      sendFrame(4'(m), m);
      checkNext(4'(m), m);
    end
  endtask

  task automatic tStall();
    slow <= 1'b1;
    nRefused = 0;
    // eight frames: the last four each wait a full drain period
    for (int i = 0; i < 8; i++) sendFrame(4'h2, 20 + i);
    for (int i = 0; i < 8; i++) checkNext(4'h2, 20 + i);
    chkBit(nRefused > 12, 1'b1, "full buffer did not stall");
    repeat (2) @(negedge clk);
    chkBit(frameValid, 1'b0, "buffer not empty");
    slow <= 1'b0;
  endtask

  task automatic tBadMode();
    logic [3:0] bad[4] = '{4'h0, 4'h1, 4'hb, 4'hf};
    foreach (bad[i]) begin
      @(posedge clk);
      linkFormatMode <= bad[i];
      sampleValid <= 1'b1;
      sampleA <= smp(0, 0, 40);
      sampleB <= smp(1, 0, 40);
      sampleC <= smp(2, 0, 40);
      sampleD <= smp(3, 0, 40);
      repeat (4) @(negedge clk);
      chkBit(modeError, 1'b1, "unsupported mode not flagged");
      chkBit(sampleReady, 1'b0, "ready in unsupported mode");
    end
    chkBit(i_alsp_frame_sink.got.size() == 0, 1'b1, "frame while halted");
    sendFrame(4'h2, 40);
    checkNext(4'h2, 40);
    chkBit(modeError, 1'b0, "mode error after recovery");
  endtask

  initial begin
    rst_b = 1'b0;
    linkFormatMode = 4'h2;
    sampleValid = 1'b0;
    sampleA = '0;
    sampleB = '0;
    sampleC = '0;
    sampleD = '0;
    slow = 1'b0;
    nFail = 0;
    cmpCount = 0;
    nRefused = 0;
    repeat (20) @(posedge clk);
    tReset();
    tModes();
    tStall();
    tBadMode();
    giveVerdict();
  end

  // a hang ends the run as a failure, well past the expected length
  initial begin
    repeat (20000) @(posedge clk);
    nFail++;
    giveVerdict();
  end
endmodule // adc_sample_lane_packer_tb
